// ===== ids_pkg.sv
package ids_pkg;

    // ==========================================================
    // Sizes
    localparam int RAM_BYTES_MAX = 256;
    localparam int IRQ_COUNT = 6;
    localparam int NUM_SFR = 27;
    localparam logic [4:0] SFR_NONE = 5'h1f;

    // ==========================================================
    // Address spaces
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam int SFR_SEL_BIT = 7;
    localparam logic [2:0] BIT_LANE_ZERO = 3'h0;
    localparam logic [2:0] BANK_PAD = 3'h0;
    localparam logic [3:0] BIT_BYTE_PAD = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] SP_STEP = 8'h01;

    // ==========================================================
    // Special function register map, reset values, writable bits
    localparam logic [7:0] SFR_ADDR [NUM_SFR] = '{
        8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
        8'h8c, 8'h8d, 8'h90, 8'h98, 8'h99, 8'ha0, 8'ha8, 8'hb0, 8'hb8,
        8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'he0, 8'hf0, 8'hf8};
    localparam logic [7:0] SFR_RST [NUM_SFR] = '{
        8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int IX_P0 = 0;
    localparam int IX_SP = 1;
    localparam int IX_POWER_CONTROL = 4;
    localparam int IX_IE = 15;
    localparam int IX_IP = 17;
    localparam int IX_PSW = 23;
    localparam int IX_ACC = 24;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_PSW = 8'hfe;
    localparam logic [7:0] MASK_POWER_CONTROL = 8'hef;
    localparam logic [7:0] MASK_IEIP = 8'hbf;

    // ==========================================================
    // Field positions
    localparam int PSW_PARITY = 0;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_BANK_HI = 4;
    localparam int POWER_CONTROL_IDLE = 0;
    localparam int POWER_CONTROL_STOP = 1;
    localparam int POWER_CONTROL_RESUME = 5;
    localparam int POWER_CONTROL_PIN_PD = 6;
    localparam int POWER_CONTROL_BAUD = 7;
    localparam int IE_ALL = 7;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        OP_DIR = 3'h0,
        OP_IND = 3'h1,
        OP_BIT = 3'h2,
        OP_PUSH = 3'h3,
        OP_POP = 3'h4,
        OP_REG = 3'h5,
        OP_XDM = 3'h6
    } ids_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } ids_state_t;

    typedef struct packed {
        logic valid;
        ids_op_t op;
        logic wr;
        logic [7:0] addr;
        logic [15:0] xaddr;
        logic [7:0] wdata;
    } ids_req_t;

    typedef struct packed {
        logic stb;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ids_xdm_t;

    typedef struct packed {
        logic [7:0] sp;
        logic [7:0] program_status;
        logic [1:0] bank;
        logic baud_double;
        logic osc_stop;
        logic cpu_halt;
    } ids_stat_t;

endpackage

// ===== ids_ram.sv
`timescale 1ns/1ns
module ids_ram
    import ids_pkg::*;
#(
    parameter int DEPTH = RAM_BYTES_MAX,
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    // ==========================================================
    // Storage
    // Contents survive reset, as on-chip data RAM does
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule // ids_ram

// ===== ids_core.sv
`timescale 1ns/1ns
module ids_core
    import ids_pkg::*;
#(
    parameter int RAM_BYTES = RAM_BYTES_MAX,
    parameter int NUM_IRQ = IRQ_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ids_req_t req,
    output logic ready_r,
    output logic rsp_valid_r,
    output logic [7:0] rsp_data_r,
    input wire logic instr_cycle,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic power_down_pin,
    output ids_xdm_t xdm_r,
    input wire logic [7:0] xdm_rdata,
    output ids_stat_t status_r,
    output logic wake_call_r,
    output logic wake_resume_r
);

    // ==========================================================
    // Functions
    function automatic logic [4:0] sfr_idx(input logic [7:0] a);
        logic [4:0] k;
        k = SFR_NONE;
        for (int i = 0; i < NUM_SFR; i++) begin
            if (a == SFR_ADDR[i]) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction

    // Reserved bits stay zero whatever software writes
    function automatic logic [7:0] sfr_wmask(input logic [4:0] k);
        logic [7:0] m;
        m = MASK_ALL;
        if (k == 5'(IX_PSW)) begin
            m = MASK_PSW;
        end else if (k == 5'(IX_POWER_CONTROL)) begin
            m = MASK_POWER_CONTROL;
        end else if (k == 5'(IX_IE) || k == 5'(IX_IP)) begin
            m = MASK_IEIP;
        end
        return m;
    endfunction

    function automatic logic [7:0] ram_addr_of(input ids_req_t q, input logic [7:0] sp,
                                               input logic [1:0] bank);
        logic [7:0] a;
        a = q.addr;
        case (q.op)
            OP_PUSH: a = sp + SP_STEP;
            OP_POP: a = sp;
            OP_REG: a = {BANK_PAD, bank, q.addr[2:0]};
            OP_BIT: a = BIT_RAM_BASE + {BIT_BYTE_PAD, q.addr[6:3]};
            default: a = q.addr;
        endcase
        return a;
    endfunction

    // ==========================================================
    // State
    logic [7:0] sfr_r [NUM_SFR];
    ids_state_t state_r;
    ids_req_t q_r;
    logic [7:0] ram_a_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_d_r;
    logic pin_pd_r;

    // ==========================================================
    // Decode
    wire logic [7:0] sp_w = sfr_r[IX_SP];
    wire logic [7:0] psw_w = sfr_r[IX_PSW];
    wire logic [7:0] power_control_w = sfr_r[IX_POWER_CONTROL];
    wire logic [7:0] ie_w = sfr_r[IX_IE];
    wire logic [7:0] acc_w = sfr_r[IX_ACC];
    // Bank field resets to zero with status word
    // Two select bits form the bank number
    wire logic [1:0] bank_w = {psw_w[PSW_BANK_HI], psw_w[PSW_BANK_LO]};
    wire logic take = req.valid && ready_r;
    wire logic waiting = (state_r == ST_WAIT);
    wire logic [7:0] ram_ra = ram_addr_of(req, sp_w, bank_w);
    wire logic [7:0] ram_rd;

    // Direct high addresses decode as SFR space
    wire logic hi_addr = q_r.addr[SFR_SEL_BIT];
    // Low half reached both directly and indirectly
    wire logic dir_like = (q_r.op == OP_DIR) || (q_r.op == OP_BIT);
    wire logic ram_space = !(dir_like && hi_addr) && (q_r.op != OP_XDM);
    // Upper half exists only on larger variants
    wire logic in_range = int'(ram_a_r) < RAM_BYTES;
    wire logic is_ram = ram_space && in_range;
    // Bit address names byte at multiple of eight
    wire logic [7:0] sfr_a = (q_r.op == OP_BIT) ? {q_r.addr[7:3], BIT_LANE_ZERO} : q_r.addr;
    wire logic [4:0] sfr_k = sfr_idx(sfr_a);
    // Power control sits off the bit grid so a bit access never matches it
    wire logic sfr_ok = dir_like && hi_addr && (sfr_k != SFR_NONE);
    wire logic [7:0] sfr_rd = sfr_ok ? sfr_r[sfr_k] : BYTE_ZERO;
    wire logic [7:0] byte_val = (q_r.op == OP_XDM) ? xdm_rdata : (is_ram ? ram_rd : sfr_rd);
    wire logic bit_val = byte_val[q_r.addr[2:0]];

    // Bit write is a read-modify-write of its byte
    logic [7:0] bit_merged;
    always_comb begin
        bit_merged = byte_val;
        bit_merged[q_r.addr[2:0]] = q_r.wdata[0];
    end
    wire logic [7:0] wbyte = (q_r.op == OP_BIT) ? bit_merged : q_r.wdata;

    // Push writes through the indirect RAM port
    wire logic ram_we = waiting && is_ram && (q_r.op != OP_POP) && (q_r.wr || q_r.op == OP_PUSH);
    wire logic sfr_we = waiting && sfr_ok && q_r.wr;
    wire logic [7:0] sfr_mask = sfr_wmask(sfr_k);

    // ==========================================================
    // Power management
    // Interrupt enables gate only the non-resume wake path
    wire logic [NUM_IRQ-1:0] irq_en = irq_req & ie_w[NUM_IRQ-1:0] & {NUM_IRQ{ie_w[IE_ALL]}};
    wire logic any_en = |irq_en;
    wire logic mode_on = power_control_w[POWER_CONTROL_IDLE] || power_control_w[POWER_CONTROL_STOP] || pin_pd_r;
    // Resume select lets any request wake
    wire logic wake = mode_on && (power_control_w[POWER_CONTROL_RESUME] ? |irq_req : any_en);
    wire logic pin_fall = pin_d_r && !pin_s2_r;
    wire logic pin_rise = !pin_d_r && pin_s2_r;

    // ==========================================================
    // RAM
    ids_ram #(
        .DEPTH(RAM_BYTES_MAX),
        .AW(8),
        .DW(8)
    ) u_ram (
        .sys_clk(sys_clk),
        .we(ram_we),
        .waddr(ram_a_r),
        .wdata(wbyte),
        .raddr(ram_ra),
        .rdata(ram_rd)
    );

    // ==========================================================
    // Access sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b1;
            q_r <= '0;
            ram_a_r <= BYTE_ZERO;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= BYTE_ZERO;
            xdm_r <= '0;
        end else begin
            rsp_valid_r <= 1'b0;
            xdm_r.stb <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        q_r <= req;
                        ram_a_r <= ram_ra;
                        ready_r <= 1'b0;
                        state_r <= ST_WAIT;
                        // External move leaves as its own strobe
                        if (req.op == OP_XDM) begin
                            xdm_r <= '{stb: 1'b1, wr: req.wr, addr: req.xaddr,
                                       wdata: req.wdata};
                        end
                    end
                end
                ST_WAIT: begin
                    rsp_valid_r <= 1'b1;
                    rsp_data_r <= (q_r.op == OP_BIT) ? {7'h00, bit_val} : byte_val;
                    ready_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Special function registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Reset values: ports ones, pointer 07
            for (int i = 0; i < NUM_SFR; i++) begin
                sfr_r[i] <= SFR_RST[i];
            end
        end else begin
            // Wake clears stop and idle requests
            if (wake) begin
                sfr_r[IX_POWER_CONTROL][POWER_CONTROL_STOP] <= 1'b0;
                sfr_r[IX_POWER_CONTROL][POWER_CONTROL_IDLE] <= 1'b0;
            end
            // Masked write keeps user flags plain
            if (sfr_we) begin
                sfr_r[sfr_k] <= (wbyte & sfr_mask) | (sfr_r[sfr_k] & ~sfr_mask);
            end
            if (waiting && q_r.op == OP_PUSH) begin
                sfr_r[IX_SP] <= sp_w + SP_STEP;
            end else if (waiting && q_r.op == OP_POP) begin
                sfr_r[IX_SP] <= sp_w - SP_STEP;
            end
            if (instr_cycle) begin
                sfr_r[IX_PSW][PSW_PARITY] <= ^acc_w;
            end
        end
    end

    // ==========================================================
    // Pin power-down and outputs
    // Pin is asynchronous, two flops before any edge logic
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_d_r <= 1'b1;
            pin_pd_r <= 1'b0;
            wake_call_r <= 1'b0;
            wake_resume_r <= 1'b0;
            status_r <= '0;
        end else begin
            pin_s1_r <= power_down_pin;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
            // Falling edge enters, rising edge leaves
            if (power_control_w[POWER_CONTROL_PIN_PD] && pin_fall) begin
                pin_pd_r <= 1'b1;
            end else if (pin_rise || wake) begin
                pin_pd_r <= 1'b0;
            end
            wake_call_r <= wake && any_en;
            wake_resume_r <= wake && !any_en;
            // Idle flag mirrored as CPU halt
            // Baud doubler and mode flags exported
            status_r <= '{sp: sp_w, program_status: psw_w, bank: bank_w,
                          baud_double: power_control_w[POWER_CONTROL_BAUD],
                          osc_stop: power_control_w[POWER_CONTROL_STOP] || pin_pd_r,
                          cpu_halt: power_control_w[POWER_CONTROL_IDLE]};
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_take_op(ids_op_t o);
        take && req.op == o;
    endsequence

    sequence s_answer;
        ##2 rsp_valid_r;
    endsequence

    sequence s_wake_by(logic en);
        wake && (any_en == en);
    endsequence

    a_answer_two_cycles: assert property (take |-> s_answer)
        else $error("answer not two cycles after request");
    a_sp_after_reset: assert property ($fell(rst) |-> sp_w == SP_RESET)
        else $error("stack pointer not 07 after reset");
    a_push_preincr: assert property (s_take_op(OP_PUSH) |-> ##1 (ram_we && ram_a_r ==
        $past(sp_w) + SP_STEP) ##1 sp_w == $past(sp_w, 2) + SP_STEP)
        else $error("push did not pre-increment");
    a_bank_address: assert property (s_take_op(OP_REG) |->
        ram_ra == {BANK_PAD, bank_w, req.addr[2:0]})
        else $error("working register bank mapping wrong");
    a_bit_ram_map: assert property (s_take_op(OP_BIT) && !req.addr[SFR_SEL_BIT] |->
        ram_ra == BIT_RAM_BASE + {BIT_BYTE_PAD, req.addr[6:3]})
        else $error("bit address maps to wrong byte");
    a_direct_no_ram: assert property (s_take_op(OP_DIR) && req.addr[SFR_SEL_BIT] |->
        ##1 !ram_we)
        else $error("direct high access wrote RAM");
    a_parity_track: assert property (instr_cycle |=>
        psw_w[PSW_PARITY] == ^$past(acc_w))
        else $error("parity flag does not follow accumulator");
    a_power_control_no_bit: assert property (waiting && q_r.op == OP_BIT |=>
        $stable(power_control_w[POWER_CONTROL_BAUD:POWER_CONTROL_PIN_PD]))
        else $error("bit access changed power control");
    a_pin_pd_entry: assert property (power_control_w[POWER_CONTROL_PIN_PD] && pin_fall |=> ##1
        status_r.osc_stop)
        else $error("pin falling edge missed power-down");
    // A software write to power control in the wake cycle wins, so it is left out
    a_resume_wake: assert property (mode_on && power_control_w[POWER_CONTROL_RESUME] && |irq_req &&
        !(sfr_we && sfr_k == 5'(IX_POWER_CONTROL)) |=>
        !power_control_w[POWER_CONTROL_IDLE] && !power_control_w[POWER_CONTROL_STOP] && (wake_call_r || wake_resume_r))
        else $error("resume-select wake did not end the mode");
    a_wake_vector: assert property (s_wake_by(1'b1) |=>
        wake_call_r && !wake_resume_r)
        else $error("enabled wake did not call the vector");
    a_wake_inline: assert property (s_wake_by(1'b0) |=>
        wake_resume_r && !wake_call_r)
        else $error("disabled wake did not resume inline");
    a_pin_pd_exit: assert property (pin_rise |=>
        !pin_pd_r)
        else $error("pin rising edge did not end power-down");
    a_xdm_strobe: assert property (s_take_op(OP_XDM) |=>
        xdm_r.stb && xdm_r.addr == $past(req.xaddr))
        else $error("external move strobe missing");
    a_reset_ports: assert property ($fell(rst) |->
        sfr_r[IX_P0] == MASK_ALL && psw_w == BYTE_ZERO)
        else $error("port or status word wrong after reset");
    a_halt_mirror: assert property (power_control_w[POWER_CONTROL_IDLE] |=>
        status_r.cpu_halt)
        else $error("idle request not shown as CPU halt");

endmodule // ids_core

// ===== ids_xmem.sv
`timescale 1ns/1ns
// ==========================================================
// External data store answering single-strobe moves
module ids_xmem
    import ids_pkg::*;
(
    input wire logic sys_clk,
    input wire ids_xdm_t xdm,
    output logic [7:0] rdata
);
    logic [7:0] mem_r [65536];
    wire logic live = xdm.stb && !xdm.wr;

    always_ff @(posedge sys_clk) begin
        if (xdm.stb && xdm.wr) begin
            mem_r[xdm.addr] <= xdm.wdata;
        end
    end

    // Data stand while a read strobe does, since the core samples them at that edge;
    // outside it the bus shows junk, so stale data never passes
    assign rdata = live ? mem_r[xdm.addr] : ~mem_r[xdm.addr];
endmodule // ids_xmem

// ===== ids_core_test.sv
`timescale 1ns/1ns
module ids_core_test
    import ids_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ids_req_t req = '0;
    logic instr_cycle = 1'b0;
    logic [IRQ_COUNT-1:0] irq_req = '0;
    logic power_down_pin = 1'b1;
    logic ready_r, rsp_valid_r, wake_call_r, wake_resume_r;
    logic [7:0] rsp_data_r, xdm_rdata;
    ids_xdm_t xdm_r;
    ids_stat_t status_r;
    int miscompares = 0;
    int samples_checked = 0;
    int calls_seen = 0;
    int resumes_seen = 0;
    logic [7:0] seed = 8'h39;

    // ==========================================================
    // Clock, reset, parts
    always #25 sys_clk = ~sys_clk;
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
    end

    ids_core i_ids_core (.sys_clk(sys_clk), .rst(rst), .req(req), .ready_r(ready_r),
        .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .instr_cycle(instr_cycle),
        .irq_req(irq_req), .power_down_pin(power_down_pin), .xdm_r(xdm_r),
        .xdm_rdata(xdm_rdata), .status_r(status_r), .wake_call_r(wake_call_r),
        .wake_resume_r(wake_resume_r));
    ids_xmem i_ids_xmem (.sys_clk(sys_clk), .xdm(xdm_r), .rdata(xdm_rdata));

    // Pulses are counted mid-cycle to stay clear of the launching edge
    always @(negedge sys_clk) begin
        if (wake_call_r === 1'b1) calls_seen++;
        if (wake_resume_r === 1'b1) resumes_seen++;
    end

    // ==========================================================
    // Helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] status_word(input logic [7:0] flags, input logic [7:0] acc);
        return (flags & 8'hfe) | {7'h00, ^acc};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic access(input ids_op_t op, input logic wr, input logic [7:0] addr,
            input logic [7:0] wdata, input logic [15:0] xaddr, output logic [7:0] rdata);
        int n;
        @(posedge sys_clk);
        req <= '{valid: 1'b1, op: op, wr: wr, addr: addr, xaddr: xaddr, wdata: wdata};
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (ready_r !== 1'b1 && n < 8);
        @(posedge sys_clk);
        req <= '0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (rsp_valid_r !== 1'b1 && n < 8);
        check(8'(n), 8'h02, "answer latency");
        rdata = rsp_data_r;
    endtask

    task automatic put(input ids_op_t op, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        access(op, 1'b1, a, d, 16'h0000, x);
    endtask

    task automatic get(input ids_op_t op, input logic [7:0] a, output logic [7:0] d);
        access(op, 1'b0, a, 8'h00, 16'h0000, d);
    endtask

    task automatic wake_case(input logic [7:0] power_control, input logic [7:0] ie, input logic [1:0] how);
        int c0;
        int r0;
        put(OP_DIR, 8'ha8, ie);
        put(OP_DIR, 8'h87, power_control);
        settle();
        c0 = calls_seen;
        r0 = resumes_seen;
        check({6'h00, status_r.osc_stop, status_r.cpu_halt},
            {6'h00, power_control[1:0]}, "mode entry");
        @(posedge sys_clk);
        irq_req <= 6'h01;
        settle();
        @(posedge sys_clk);
        irq_req <= 6'h00;
        settle();
        check({6'h00, status_r.osc_stop, status_r.cpu_halt},
            (how == 2'h0) ? {6'h00, power_control[1:0]} : 8'h00, "mode exit");
        check(8'(calls_seen - c0), {7'h00, how == 2'h1}, "vector call");
        check(8'(resumes_seen - r0), {7'h00, how == 2'h2}, "inline resume");
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        give_verdict();
    end

    // ==========================================================
    // Scenarios
    initial begin
        logic [7:0] x, d, a;
        logic [15:0] xa;
        wait (rst == 1'b0);
        for (int i = 0; i < NUM_SFR; i++) begin
            get(OP_DIR, SFR_ADDR[i], x);
            check(x, SFR_RST[i], "reset value");
        end
        check(status_r.sp, 8'h07, "reset pointer");
        check({6'h00, status_r.bank}, 8'h00, "reset bank");
        put(OP_PUSH, 8'h00, 8'h5c);
        get(OP_DIR, 8'h08, x);
        check(x, 8'h5c, "first stacked byte");
        get(OP_POP, 8'h00, x);
        check(x, 8'h5c, "pop value");
        put(OP_DIR, 8'h81, 8'h9f);
        put(OP_PUSH, 8'h00, 8'h3e);
        get(OP_IND, 8'ha0, x);
        check(x, 8'h3e, "stack in upper half");
        get(OP_DIR, 8'ha0, x);
        check(x, 8'hff, "port untouched by stack");
        put(OP_DIR, 8'h81, 8'h07);
        put(OP_DIR, 8'h80, 8'haa);
        put(OP_IND, 8'h80, 8'hbb);
        get(OP_DIR, 8'h80, x);
        check(x, 8'haa, "direct high byte");
        get(OP_IND, 8'h80, x);
        check(x, 8'hbb, "indirect high byte");
        put(OP_DIR, 8'h84, 8'h5a);
        get(OP_DIR, 8'h84, x);
        check(x, 8'h00, "undefined register");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr_next(seed);
            a = {1'b1, seed[6:0]};
            d = lfsr_next(seed);
            put(OP_IND, a, d);
            get(OP_IND, a, x);
            check(x, d, "upper ram");
            a = {2'b01, d[5:0]};
            put(OP_DIR, a, seed);
            get(OP_IND, a, x);
            check(x, seed, "low ram both ways");
        end
        for (int b = 0; b < 4; b++) begin
            seed = lfsr_next(seed);
            put(OP_DIR, 8'hd0, 8'(b << 3));
            settle();
            check({6'h00, status_r.bank}, 8'(b), "bank field");
            put(OP_REG, {5'h00, seed[2:0]}, ~seed);
            get(OP_DIR, 8'(b * 8) | {5'h00, seed[2:0]}, x);
            check(x, ~seed, "working register place");
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            a = BIT_RAM_BASE + {4'h0, seed[6:3]};
            put(OP_DIR, a, 8'h00);
            put(OP_BIT, {1'b0, seed[6:0]}, 8'h01);
            get(OP_DIR, a, x);
            check(x, 8'h01 << seed[2:0], "bit into byte");
            put(OP_BIT, {5'b10010, seed[2:0]}, 8'h00);
            get(OP_DIR, 8'h90, x);
            check(x, ~(8'h01 << seed[2:0]), "register bit");
            put(OP_DIR, 8'h90, 8'hff);
            put(OP_DIR, 8'he0, seed);
            @(posedge sys_clk);
            instr_cycle <= 1'b1;
            @(posedge sys_clk);
            instr_cycle <= 1'b0;
            put(OP_DIR, 8'hd0, 8'h23);
            get(OP_DIR, 8'hd0, x);
            check(x, status_word(8'h22, seed), "status word");
            check(status_r.program_status, status_word(8'h22, seed), "status mirror");
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            xa = {seed, ~seed};
            access(OP_XDM, 1'b1, 8'h00, seed ^ 8'h6d, xa, x);
            access(OP_XDM, 1'b0, 8'h00, 8'h00, xa, x);
            check(x, seed ^ 8'h6d, "external move");
        end
        put(OP_DIR, 8'h87, 8'h80);
        settle();
        check({7'h00, status_r.baud_double}, 8'h01, "baud doubler");
        put(OP_BIT, 8'h87, 8'h00);
        get(OP_DIR, 8'h87, x);
        check(x, 8'h80, "power control kept");
        get(OP_DIR, 8'h80, x);
        check(x, 8'h2a, "bit lands in port");
        wake_case(8'h01, 8'h01, 2'h0);
        wake_case(8'h01, 8'h81, 2'h1);
        wake_case(8'h21, 8'h00, 2'h2);
        wake_case(8'h02, 8'h81, 2'h1);
        wake_case(8'h22, 8'h00, 2'h2);
        for (int en = 0; en < 2; en++) begin
            put(OP_DIR, 8'h87, en ? 8'h40 : 8'h00);
            @(posedge sys_clk);
            power_down_pin <= 1'b0;
            repeat (8) @(negedge sys_clk);
            check({7'h00, status_r.osc_stop}, 8'(en), "pin entry");
            @(posedge sys_clk);
            power_down_pin <= 1'b1;
            repeat (8) @(negedge sys_clk);
            check({7'h00, status_r.osc_stop}, 8'h00, "pin exit");
        end
        give_verdict();
    end
endmodule // ids_core_test
